// file: hw/local_bus_chip_select_map_regs.svh
// Purpose: named constants for the local bus chip select steering block
// Assumes: included by the package and by every design file that needs a figure
// Notes: definitions only, no logic
`ifndef LOCAL_BUS_CHIP_SELECT_MAP_REGS_SVH
`define LOCAL_BUS_CHIP_SELECT_MAP_REGS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define LBM_LANES 32
`define LBM_CS_NUM 8
`define LBM_MAP_W 2
`define LBM_NOR_W 16
`define LBM_BYTE_W 8
`define LBM_FADDR_W 26
`define LBM_CTRL_W 16
`define LBM_DEV_DATA_W 32

// ****************************************************************
// chip select numbers
// ****************************************************************
`define LBM_CS0 0
`define LBM_CS1 1
`define LBM_CS2 2
`define LBM_CS3 3
`define LBM_CS4 4
`define LBM_CS5 5
`define LBM_CS6 6
`define LBM_CS7 7

// ****************************************************************
// field positions
// ****************************************************************
`define LBM_FTOP 25
`define LBM_NOR_MSB 15
`define LBM_BYTE_MSB 7

// ****************************************************************
// reset values
// ****************************************************************
`define LBM_CTRL_RST 16'h3FD3
`define LBM_ZERO32 32'h0000_0000
`define LBM_ZERO26 26'h000_0000
`define LBM_ZERO16 16'h0000
`define LBM_ZERO8 8'h00
`define LBM_CE_OFF 5'h1F
`define LBM_STROBE_RST 5'h19
`define LBM_ONE 1'h1
`define LBM_NIL 1'h0

`endif

// file: hw/local_bus_chip_select_map_pkg.sv
// Purpose: types shared by the chip select steering block
// Assumes: the constants header is found on the include path
// Notes: nothing here is imported; users write the package name
`include "local_bus_chip_select_map_regs.svh"
`default_nettype none

package local_bus_chip_select_map_pkg;

  // ****************************************************************
  // boot map settings
  // ****************************************************************
  typedef enum logic [`LBM_MAP_W-1:0] {
    MAP_NOR_BOOT  = 2'b00,
    MAP_EMU_BOOT  = 2'b01,
    MAP_NAND_BOOT = 2'b10,
    MAP_NOR_SWAP  = 2'b11
  } boot_map_e;

  // synchronised control pins, msb first
  typedef struct packed {
    logic [`LBM_MAP_W-1:0] boot_map_setting;
    logic [`LBM_CS_NUM-1:0] bus_chip_select_n;
    logic addr_latch_strobe;
    logic byte0_write_strobe_n;
    logic nand_cmd_latch_out;
    logic nand_addr_latch_out;
    logic nand_read_strobe_n;
    logic nand_ready_busy_n;
  } pin_ctrl_s;

  // per device enables, active low
  typedef struct packed {
    logic nor_n;
    logic emu_n;
    logic nand_n;
    logic ctrl_n;
    logic sram_n;
  } dev_enable_s;

  // strobes toward the flash devices
  typedef struct packed {
    logic nor_we_n;
    logic nand_we_n;
    logic nand_cle;
    logic nand_ale;
    logic nand_re_n;
  } strobe_s;

endpackage : local_bus_chip_select_map_pkg

`default_nettype wire

// file: hw/pin_sync3.sv
// Purpose: three flop synchroniser for pin inputs
// Assumes: one clock, synchronous active high reset
// Notes: a bit changes once the second and third stages agree
`include "local_bus_chip_select_map_regs.svh"
`default_nettype none

module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_sys_clk,      // system clock
  input wire logic i_rst,          // synchronous reset
  input wire logic [W-1:0] i_pin,  // raw pin level
  output logic [W-1:0] o_level     // filtered level
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_level;

  // accept per bit where stages two and three agree
  always_comb begin
    for (int b = 0; b < W; b++) begin
      next_level[b] = (stage2[b] == stage3[b]) ? stage3[b] : o_level[b];
    end
  end

  // stage chain and filtered output
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      stage1 <= RST;
      stage2 <= RST;
      stage3 <= RST;
      o_level <= RST;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
      o_level <= next_level;
    end
  end

endmodule : pin_sync3

`default_nettype wire

// file: hw/addr_demux_latch.sv
// Purpose: address demultiplexing latch on the shared address/data lanes
// Assumes: lanes and strobe already synchronised to the system clock
// Notes: follows the lanes while the strobe is high, holds after it falls
`include "local_bus_chip_select_map_regs.svh"
`default_nettype none

module addr_demux_latch (
  input wire logic i_sys_clk,                     // system clock
  input wire logic i_rst,                         // synchronous reset
  input wire logic i_addr_latch_strobe,           // address phase, high
  input wire logic [`LBM_LANES-1:0] i_lanes,      // shared lanes
  output logic [`LBM_LANES-1:0] o_addr            // held address
);

  logic [`LBM_LANES-1:0] next_addr;

  // transparent while the strobe is high
  always_comb begin
    next_addr = i_addr_latch_strobe ? i_lanes : o_addr;
  end

  // held address register
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_addr <= `LBM_ZERO32;
    end else begin
      o_addr <= next_addr;
    end
  end

endmodule : addr_demux_latch

`default_nettype wire

// file: hw/local_bus_chip_select_map.sv
// Purpose: steer the local bus chip selects, strobes and data lanes to
//   the board memories and the control register space
// Assumes: 20 MHz system clock, synchronous active high reset,
//   every pin input passes four flops (three stages and the filtered output) before use
// Notes: every output is a flop, so pin to pin latency is several cycles
//
// Overview of operation
// - map 00: cs0 NOR, cs1 emulator, cs2/cs4-6 NAND, cs3 control, cs7 SRAM.
// - map 01: cs0 and cs1 exchange, emulator on cs0, NOR on cs1.
// - map 10: cs2 NOR, cs0 plus cs4-6 NAND, cs1 emulator.
// - map 11: same as 00 with flash half swap on.
// - swap applied by exclusive-or on the flash top address bit only.
// - swap off passes flash address bit 25 unchanged.
// - swap on inverts flash address bit 25.
// - address comes from the internal addr_demux_latch instance on the shared lanes.
// - NOR data: lanes 0-15 onto flash bits 15 down to 0.
// - NAND data: lanes 0-7 onto NAND bits 7 down to 0.
// - control space data: lanes 0-7 onto bits 7 down to 0.
// - NAND write enable follows the shared byte 0 write strobe.
// - NAND command latch enable follows the command latch output.
// - NAND read strobe follows the shared read enable output.
// - NAND ready/busy returns on the shared wait/acknowledge line.
// - NOR write enable follows the byte 0 write strobe.
`include "local_bus_chip_select_map_regs.svh"
`default_nettype none

module local_bus_chip_select_map (
  input wire logic i_sys_clk,                              // 20 MHz clock
  input wire logic i_rst,                                  // sync reset
  input wire logic [`LBM_MAP_W-1:0] i_boot_map_setting,    // boot map strap
  input wire logic [`LBM_CS_NUM-1:0] i_bus_chip_select_n,  // selects, low
  input wire logic i_addr_latch_strobe,                    // address phase
  input wire logic i_byte0_write_strobe_n,                 // shared write
  input wire logic i_nand_cmd_latch_out,                   // NAND cmd latch
  input wire logic i_nand_addr_latch_out,                  // NAND addr latch
  input wire logic i_nand_read_strobe_n,                   // shared read
  input wire logic i_nand_ready_busy_n,                    // NAND busy, low
  input wire logic [`LBM_LANES-1:0] i_muxed_addr_data_lines, // lanes in
  output logic [`LBM_LANES-1:0] o_muxed_addr_data_lines,   // lanes out
  output logic o_muxed_addr_data_oe,                       // lanes drive
  output logic o_gp4_wait_ack_line,                        // busy return
  output local_bus_chip_select_map_pkg::dev_enable_s o_dev_en, // enables
  output local_bus_chip_select_map_pkg::strobe_s o_strobe,     // strobes
  output logic o_flash_half_swap,                          // swap active
  output logic [`LBM_FADDR_W-1:0] o_flash_addr,            // flash address
  input wire logic [`LBM_NOR_W-1:0] i_nor_data,            // NOR data in
  output logic [`LBM_NOR_W-1:0] o_nor_data,                // NOR data out
  output logic o_nor_data_oe,                              // NOR drive
  input wire logic [`LBM_BYTE_W-1:0] i_nand_data,          // NAND data in
  output logic [`LBM_BYTE_W-1:0] o_nand_data,              // NAND data out
  output logic o_nand_data_oe,                             // NAND drive
  input wire logic [`LBM_BYTE_W-1:0] i_ctrl_data,          // ctrl data in
  output logic [`LBM_BYTE_W-1:0] o_ctrl_data,              // ctrl data out
  output logic o_ctrl_data_oe                              // ctrl drive
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************

  local_bus_chip_select_map_pkg::pin_ctrl_s ctl;
  logic [`LBM_CTRL_W-1:0] ctl_raw;
  logic [`LBM_CTRL_W-1:0] ctl_sync;
  logic [`LBM_LANES-1:0] lanes;
  logic [`LBM_DEV_DATA_W-1:0] dev_raw;
  logic [`LBM_DEV_DATA_W-1:0] dev_sync;
  logic [`LBM_NOR_W-1:0] nor_in;
  logic [`LBM_BYTE_W-1:0] nand_in;
  logic [`LBM_BYTE_W-1:0] ctrl_in;

  // gather control pins in struct order
  assign ctl_raw = {i_boot_map_setting, i_bus_chip_select_n,
                    i_addr_latch_strobe, i_byte0_write_strobe_n,
                    i_nand_cmd_latch_out, i_nand_addr_latch_out,
                    i_nand_read_strobe_n, i_nand_ready_busy_n};
  assign ctl = ctl_sync;

  // control pins settle to idle levels under reset
  pin_sync3 #(
    .W(`LBM_CTRL_W),
    .RST(`LBM_CTRL_RST)
  ) u_sync_ctl (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin(ctl_raw),
    .o_level(ctl_sync)
  );

  // shared address/data lanes
  pin_sync3 #(
    .W(`LBM_LANES),
    .RST(`LBM_ZERO32)
  ) u_sync_lanes (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin(i_muxed_addr_data_lines),
    .o_level(lanes)
  );

  // data returned by the memories
  assign dev_raw = {i_nor_data, i_nand_data, i_ctrl_data};
  assign nor_in = dev_sync[`LBM_DEV_DATA_W-1 -: `LBM_NOR_W];
  assign nand_in = dev_sync[`LBM_NOR_W-1 -: `LBM_BYTE_W];
  assign ctrl_in = dev_sync[`LBM_BYTE_W-1:0];

  pin_sync3 #(
    .W(`LBM_DEV_DATA_W),
    .RST(`LBM_ZERO32)
  ) u_sync_dev (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin(dev_raw),
    .o_level(dev_sync)
  );

  // ****************************************************************
  // address demultiplexing
  // ****************************************************************

  logic [`LBM_LANES-1:0] bus_addr;

  // address held from the address phase of the shared lanes
  addr_demux_latch u_addr_latch (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_addr_latch_strobe(ctl.addr_latch_strobe),
    .i_lanes(lanes),
    .o_addr(bus_addr)
  );

  // ****************************************************************
  // chip select steering
  // ****************************************************************

  local_bus_chip_select_map_pkg::dev_enable_s next_dev_en;
  logic next_flash_half_swap;
  logic [`LBM_CS_NUM-1:0] cs_n;
  logic nand_grp_n;

  assign cs_n = ctl.bus_chip_select_n;

  // selects 4 to 6 always belong to the NAND group; any low one enables
  assign nand_grp_n = cs_n[`LBM_CS4] & cs_n[`LBM_CS5] & cs_n[`LBM_CS6];

  // pick each enable from the selects that the boot map assigns
  always_comb begin
    next_dev_en = `LBM_CE_OFF;
    next_flash_half_swap = `LBM_NIL;
    next_dev_en.ctrl_n = cs_n[`LBM_CS3];
    next_dev_en.sram_n = cs_n[`LBM_CS7];
    case (local_bus_chip_select_map_pkg::boot_map_e'(ctl.boot_map_setting))
      local_bus_chip_select_map_pkg::MAP_NOR_BOOT: begin
        next_dev_en.nor_n = cs_n[`LBM_CS0];
        next_dev_en.emu_n = cs_n[`LBM_CS1];
        next_dev_en.nand_n = cs_n[`LBM_CS2] & nand_grp_n;
      end
      local_bus_chip_select_map_pkg::MAP_EMU_BOOT: begin
        next_dev_en.nor_n = cs_n[`LBM_CS1];
        next_dev_en.emu_n = cs_n[`LBM_CS0];
        next_dev_en.nand_n = cs_n[`LBM_CS2] & nand_grp_n;
      end
      local_bus_chip_select_map_pkg::MAP_NAND_BOOT: begin
        next_dev_en.nor_n = cs_n[`LBM_CS2];
        next_dev_en.emu_n = cs_n[`LBM_CS1];
        next_dev_en.nand_n = cs_n[`LBM_CS0] & nand_grp_n;
      end
      local_bus_chip_select_map_pkg::MAP_NOR_SWAP: begin
        next_dev_en.nor_n = cs_n[`LBM_CS0];
        next_dev_en.emu_n = cs_n[`LBM_CS1];
        next_dev_en.nand_n = cs_n[`LBM_CS2] & nand_grp_n;
        next_flash_half_swap = `LBM_ONE;
      end
      default: begin
        next_dev_en.nor_n = cs_n[`LBM_CS0];
        next_dev_en.emu_n = cs_n[`LBM_CS1];
        next_dev_en.nand_n = cs_n[`LBM_CS2] & nand_grp_n;
      end
    endcase
  end

  // ****************************************************************
  // flash address with half swap
  // ****************************************************************

  logic [`LBM_FADDR_W-1:0] next_flash_addr;

  // only the top bit passes through the exclusive-or
  always_comb begin
    next_flash_addr = bus_addr[`LBM_FADDR_W-1:0];
    next_flash_addr[`LBM_FTOP] = bus_addr[`LBM_FTOP] ^ next_flash_half_swap;
  end

  // ****************************************************************
  // strobes
  // ****************************************************************

  local_bus_chip_select_map_pkg::strobe_s next_strobe;
  logic next_gp4;

  // strobes follow their shared controller pins
  always_comb begin
    next_strobe.nor_we_n = ctl.byte0_write_strobe_n;
    next_strobe.nand_we_n = ctl.byte0_write_strobe_n;
    next_strobe.nand_cle = ctl.nand_cmd_latch_out;
    next_strobe.nand_ale = ctl.nand_addr_latch_out;
    next_strobe.nand_re_n = ctl.nand_read_strobe_n;
    next_gp4 = ctl.nand_ready_busy_n;
  end

  // ****************************************************************
  // data lanes
  // ****************************************************************

  logic [`LBM_LANES-1:0] next_lanes_out;
  logic next_lanes_oe;
  logic [`LBM_NOR_W-1:0] next_nor_data;
  logic [`LBM_BYTE_W-1:0] next_nand_data;
  logic [`LBM_BYTE_W-1:0] next_ctrl_data;
  logic next_nor_oe;
  logic next_nand_oe;
  logic next_ctrl_oe;
  logic wr_phase;
  logic rd_phase;

  // writes drive the memories, reads drive the lanes
  assign wr_phase = ~ctl.byte0_write_strobe_n & ~ctl.addr_latch_strobe;
  assign rd_phase = ~ctl.nand_read_strobe_n & ~ctl.addr_latch_strobe;

  // lane order is reversed against each memory's bit order
  always_comb begin
    next_lanes_out = `LBM_ZERO32;
    next_nor_data = `LBM_ZERO16;
    next_nand_data = `LBM_ZERO8;
    next_ctrl_data = `LBM_ZERO8;
    for (int i = 0; i <= `LBM_NOR_MSB; i++) begin
      next_nor_data[`LBM_NOR_MSB-i] = lanes[i];
    end
    for (int i = 0; i <= `LBM_BYTE_MSB; i++) begin
      next_nand_data[`LBM_BYTE_MSB-i] = lanes[i];
      next_ctrl_data[`LBM_BYTE_MSB-i] = lanes[i];
    end
    if (~next_dev_en.nor_n) begin
      for (int i = 0; i <= `LBM_NOR_MSB; i++) begin
        next_lanes_out[i] = nor_in[`LBM_NOR_MSB-i];
      end
    end else if (~next_dev_en.nand_n) begin
      for (int i = 0; i <= `LBM_BYTE_MSB; i++) begin
        next_lanes_out[i] = nand_in[`LBM_BYTE_MSB-i];
      end
    end else if (~next_dev_en.ctrl_n) begin
      for (int i = 0; i <= `LBM_BYTE_MSB; i++) begin
        next_lanes_out[i] = ctrl_in[`LBM_BYTE_MSB-i];
      end
    end
  end

  // each memory is driven only while selected in a write
  always_comb begin
    next_nor_oe = wr_phase & ~next_dev_en.nor_n;
    next_nand_oe = wr_phase & ~next_dev_en.nand_n;
    next_ctrl_oe = wr_phase & ~next_dev_en.ctrl_n;
    next_lanes_oe = rd_phase & ~(next_dev_en.nor_n & next_dev_en.nand_n
                                 & next_dev_en.ctrl_n);
  end

  // ****************************************************************
  // output registers
  // ****************************************************************

  // every output leaves from a flop, idle levels under reset
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_dev_en <= `LBM_CE_OFF;
      o_flash_half_swap <= `LBM_NIL;
      o_flash_addr <= `LBM_ZERO26;
      o_strobe <= `LBM_STROBE_RST;
      o_gp4_wait_ack_line <= `LBM_ONE;
      o_muxed_addr_data_lines <= `LBM_ZERO32;
      o_muxed_addr_data_oe <= `LBM_NIL;
      o_nor_data <= `LBM_ZERO16;
      o_nor_data_oe <= `LBM_NIL;
      o_nand_data <= `LBM_ZERO8;
      o_nand_data_oe <= `LBM_NIL;
      o_ctrl_data <= `LBM_ZERO8;
      o_ctrl_data_oe <= `LBM_NIL;
    end else begin
      o_dev_en <= next_dev_en;
      o_flash_half_swap <= next_flash_half_swap;
      o_flash_addr <= next_flash_addr;
      o_strobe <= next_strobe;
      o_gp4_wait_ack_line <= next_gp4;
      o_muxed_addr_data_lines <= next_lanes_out;
      o_muxed_addr_data_oe <= next_lanes_oe;
      o_nor_data <= next_nor_data;
      o_nor_data_oe <= next_nor_oe;
      o_nand_data <= next_nand_data;
      o_nand_data_oe <= next_nand_oe;
      o_ctrl_data <= next_ctrl_data;
      o_ctrl_data_oe <= next_ctrl_oe;
    end
  end

endmodule : local_bus_chip_select_map

`default_nettype wire

// file: sim/chip_select_map_props.sv
// Purpose: port checks on the chip select steering block
// Assumes: pins held steady for eight clocks reach the outputs
// Notes: a settle counter quiets the checks after reset
`default_nettype none

module chip_select_map_props (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst, // sync reset, high
  input wire logic [1:0] i_boot_map_setting, // boot map strap
  input wire logic [7:0] i_bus_chip_select_n, // selects, low
  input wire logic i_byte0_write_strobe_n, // shared write
  input wire logic i_nand_cmd_latch_out, // NAND command latch
  input wire logic i_nand_read_strobe_n, // shared read
  input wire logic i_nand_ready_busy_n, // NAND ready
  input wire logic o_gp4_wait_ack_line, // busy return
  input wire local_bus_chip_select_map_pkg::dev_enable_s o_dev_en, // enables
  input wire local_bus_chip_select_map_pkg::strobe_s o_strobe, // strobes
  input wire logic o_flash_half_swap // swap active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] up_cnt;
  logic [3:0] next_up_cnt;
  logic up;
  logic [1:0] m;
  logic [7:0] c;

  // ************************
  // settle counter
  // ************************
  // count cycles since reset, saturating
  always_comb begin
    next_up_cnt = (up_cnt == 4'hF) ? up_cnt : up_cnt + 4'h1;
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      up_cnt <= 4'h0;
    end else begin
      up_cnt <= next_up_cnt;
    end
  end
  // short aliases
  assign up = up_cnt == 4'hF;
  assign m = i_boot_map_setting;
  assign c = i_bus_chip_select_n;

  // ************************
  // checks
  // ************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  rst_idle_a: assert property ($fell(i_rst) |->
    o_dev_en == 5'h1F && o_strobe == 5'h19 && !o_flash_half_swap)
    else $error("not idle after reset");
  nor_route_a: assert property (
    (up && $stable(m) && $stable(c))[*8] |->
    o_dev_en.nor_n == (m == 2'h1 ? c[1] : (m == 2'h2 ? c[2] : c[0])))
    else $error("nor enable wrong");
  nand_route_a: assert property (
    (up && $stable(m) && $stable(c))[*8] |->
    o_dev_en.nand_n == (&c[6:4] & (m == 2'h2 ? c[0] : c[2])))
    else $error("nand enable wrong");
  fixed_route_a: assert property ((up && $stable(c))[*8] |->
    o_dev_en.ctrl_n == c[3] && o_dev_en.sram_n == c[7])
    else $error("fixed enable moved");
  swap_map_a: assert property ((up && $stable(m))[*8] |->
    o_flash_half_swap == (m == 2'h3))
    else $error("half swap wrong");
  write_strobe_a: assert property (
    (up && $stable(i_byte0_write_strobe_n))[*8] |->
    o_strobe.nor_we_n == i_byte0_write_strobe_n
    && o_strobe.nand_we_n == i_byte0_write_strobe_n)
    else $error("write enable wrong");
  nand_cmd_a: assert property ((up && $stable(i_nand_cmd_latch_out))[*8] |->
    o_strobe.nand_cle == i_nand_cmd_latch_out)
    else $error("command latch wrong");
  read_strobe_a: assert property ((up && $stable(i_nand_read_strobe_n))[*8] |->
    o_strobe.nand_re_n == i_nand_read_strobe_n)
    else $error("read strobe wrong");
  busy_return_a: assert property ((up && $stable(i_nand_ready_busy_n))[*8] |->
    o_gp4_wait_ack_line == i_nand_ready_busy_n)
    else $error("busy not returned");
endmodule : chip_select_map_props

bind local_bus_chip_select_map chip_select_map_props i_props (
  .i_sys_clk(i_sys_clk),
  .i_rst(i_rst),
  .i_boot_map_setting(i_boot_map_setting),
  .i_bus_chip_select_n(i_bus_chip_select_n),
  .i_byte0_write_strobe_n(i_byte0_write_strobe_n),
  .i_nand_cmd_latch_out(i_nand_cmd_latch_out),
  .i_nand_read_strobe_n(i_nand_read_strobe_n),
  .i_nand_ready_busy_n(i_nand_ready_busy_n),
  .o_gp4_wait_ack_line(o_gp4_wait_ack_line),
  .o_dev_en(o_dev_en),
  .o_strobe(o_strobe),
  .o_flash_half_swap(o_flash_half_swap)
);

`default_nettype wire

// file: sim/host_bus_model.sv
// Purpose: host local bus controller model on the pin side
// Assumes: called at a falling edge; each phase holds the pins 8 clocks
// Notes: released lanes show the inverse of the last driven value
`default_nettype none

module host_bus_model (
  input wire logic i_sys_clk,  // system clock
  output local_bus_chip_select_map_pkg::pin_ctrl_s o_pins,  // control pins
  output logic [31:0] o_lanes  // shared lanes
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus: selects high, strobes idle
  initial begin
    o_pins = 16'h3FD3;
    o_lanes = 32'h0;
  end

  // ************************
  // one bus phase
  // ************************
  // lanes carry the address while the latch strobe is high
  task automatic phase(input local_bus_chip_select_map_pkg::pin_ctrl_s p,
                       input logic [31:0] l, input logic drive);
    o_pins = p;
    o_lanes = drive ? l : ~o_lanes;
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask : phase
endmodule : host_bus_model

`default_nettype wire

// file: sim/tb.sv
// Purpose: self-checking bench for the chip select steering block
// Assumes: outputs settle within eight clocks
// Notes: random pins from a fixed seed plus single select corners
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk;
  logic i_rst;
  logic [31:0] addr, lanes, r, dut_lanes, host_lanes;
  logic [15:0] nor_d, nor_o;
  logic [7:0] nand_d, ctrl_d, nand_o, ctrl_o;
  logic [25:0] faddr;
  logic dut_oe, swap, gp4, nor_oe, nand_oe, ctrl_oe;
  int err_count;
  int total_checks;
  local_bus_chip_select_map_pkg::pin_ctrl_s pins, host_pins;
  local_bus_chip_select_map_pkg::dev_enable_s o_dev_en;
  local_bus_chip_select_map_pkg::strobe_s o_strobe;
  wire logic [31:0] bus_lanes;

  // block drives the lanes while reading
  assign bus_lanes = dut_oe ? dut_lanes : host_lanes;

  host_bus_model i_host (.i_sys_clk(i_sys_clk), .o_pins(host_pins), .o_lanes(host_lanes));
  local_bus_chip_select_map i_dut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_boot_map_setting(pins.boot_map_setting),
    .i_bus_chip_select_n(host_pins.bus_chip_select_n),
    .i_addr_latch_strobe(host_pins.addr_latch_strobe),
    .i_byte0_write_strobe_n(host_pins.byte0_write_strobe_n),
    .i_nand_cmd_latch_out(host_pins.nand_cmd_latch_out),
    .i_nand_addr_latch_out(host_pins.nand_addr_latch_out),
    .i_nand_read_strobe_n(host_pins.nand_read_strobe_n),
    .i_nand_ready_busy_n(pins.nand_ready_busy_n),
    .i_muxed_addr_data_lines(bus_lanes), .o_muxed_addr_data_lines(dut_lanes),
    .o_muxed_addr_data_oe(dut_oe), .o_gp4_wait_ack_line(gp4),
    .o_dev_en(o_dev_en), .o_strobe(o_strobe), .o_flash_half_swap(swap),
    .o_flash_addr(faddr), .i_nor_data(nor_d), .o_nor_data(nor_o),
    .o_nor_data_oe(nor_oe), .i_nand_data(nand_d), .o_nand_data(nand_o),
    .o_nand_data_oe(nand_oe), .i_ctrl_data(ctrl_d), .o_ctrl_data(ctrl_o),
    .o_ctrl_data_oe(ctrl_oe)
  );

  // ************************
  // expectations and compare
  // ************************
  // low w bits of v in reversed order, zero above
  function automatic logic [31:0] rev(input logic [15:0] v, input int w);
    logic [31:0] x;
    x = 32'h0;
    for (int i = 0; i < w; i++) begin
      x[w - 1 - i] = v[i];
    end
    return x;
  endfunction : rev

  // enables {nor, emu, nand, ctrl, sram} from map and selects
  function automatic logic [4:0] exp_en(input logic [1:0] m, input logic [7:0] c);
    logic nor_n, emu_n, nand_n;
    nor_n = m == 2'h1 ? c[1] : (m == 2'h2 ? c[2] : c[0]);
    emu_n = m == 2'h1 ? c[0] : c[1];
    nand_n = &c[6:4] & (m == 2'h2 ? c[0] : c[2]);
    return {nor_n, emu_n, nand_n, c[3], c[7]};
  endfunction : exp_en

  task automatic check(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_outs();
    logic [4:0] en;
    logic rd_oe, wr, w, sw;
    logic [31:0] rd;
    en = exp_en(pins.boot_map_setting, pins.bus_chip_select_n);
    w = pins.byte0_write_strobe_n;
    sw = pins.boot_map_setting == 2'h3;
    rd_oe = !pins.nand_read_strobe_n && !pins.addr_latch_strobe && !(en[4] && en[2] && en[1]);
    wr = !w && !pins.addr_latch_strobe;
    rd = !en[4] ? rev(nor_d, 16) : rev({8'h00, (!en[2] ? nand_d : ctrl_d)}, 8);
    check({27'h0, o_dev_en}, {27'h0, en});
    check({27'h0, o_strobe}, {27'h0, w, w, pins.nand_cmd_latch_out,
          pins.nand_addr_latch_out, pins.nand_read_strobe_n});
    check({31'h0, swap}, {31'h0, sw});
    check({31'h0, gp4}, {31'h0, pins.nand_ready_busy_n});
    check({6'h0, faddr}, {6'h0, addr[25] ^ sw, addr[24:0]});
    check({28'h0, dut_oe, nor_oe, nand_oe, ctrl_oe},
          {28'h0, rd_oe, wr && !en[4], wr && !en[2], wr && !en[1]});
    if (rd_oe) check(dut_lanes, rd);
    if (wr && !en[4]) check({16'h0, nor_o}, rev(lanes[15:0], 16));
    if (wr && !en[2]) check({24'h0, nand_o}, rev(lanes[15:0], 8));
    if (wr && !en[1]) check({24'h0, ctrl_o}, rev(lanes[15:0], 8));
  endtask : check_outs

  // ************************
  // stimulus
  // ************************
  // one phase with fresh random side pins, then compare
  task automatic step(input logic drive);
    r = $urandom;
    pins.nand_cmd_latch_out = r[0];
    pins.nand_addr_latch_out = r[1];
    pins.nand_ready_busy_n = r[2];
    {nor_d, nand_d, ctrl_d} = $urandom;
    i_host.phase(pins, lanes, drive);
    check_outs();
  endtask : step

  task automatic reset_dut();
    i_rst = 1'b1;
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    check({22'h0, o_dev_en, o_strobe}, {22'h0, 5'h1F, 5'h19});
    i_rst = 1'b0;
    addr = 32'h0;
  endtask : reset_dut

  // address, idle, write, idle, read, idle on one device
  task automatic access(input int d);
    logic [2:0] idx;
    idx = (pins.boot_map_setting == 2'h3) ? 3'h0 : {1'b0, pins.boot_map_setting};
    idx = d == 1 ? 3'h5 : (d == 2 ? 3'h3 : idx);
    addr = $urandom;
    lanes = addr;
    pins.bus_chip_select_n = ~(8'h01 << idx);
    pins.addr_latch_strobe = 1'b1;
    step(1'b1);
    pins.addr_latch_strobe = 1'b0;
    step(1'b1);
    lanes = $urandom;
    pins.byte0_write_strobe_n = 1'b0;
    step(1'b1);
    pins.byte0_write_strobe_n = 1'b1;
    step(1'b1);
    pins.nand_read_strobe_n = 1'b0;
    step(1'b0);
    pins.nand_read_strobe_n = 1'b1;
    step(1'b1);
  endtask : access

  task automatic complete_run();
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    err_count++;
    complete_run();
  end

  // every map: all single selects, random selects, then accesses
  initial begin
    i_rst = 1'b1;
    pins = 16'h3FD3;
    lanes = 32'h0;
    err_count = 0;
    total_checks = 0;
    void'($urandom(7));
    @(negedge i_sys_clk);
    reset_dut();
    for (int m = 0; m < 4; m++) begin
      pins.boot_map_setting = m[1:0];
      for (int k = 0; k < 10; k++) begin
        r = $urandom;
        pins.bus_chip_select_n = (k < 8) ? ~(8'h01 << k) : r[7:0];
        step(1'b1);
      end
      for (int d = 0; d < 3; d++) begin
        access(d);
      end
      if (m == 1) reset_dut();
    end
    complete_run();
  end
endmodule : tb

`default_nettype wire
